// ### design/usps_pkg.sv
package usps_pkg;
   // Core clock rate.
   localparam int SYS_CLK_HZ = 25_000_000;
   // Carrier timing; the period is derived from the tick time and carrier rate.
   localparam int CARRIER_HZ = 20_000;
   localparam int CARRIER_TICK_NS = 125;
   localparam int CARRIER_TICK_HZ = 1_000_000_000 / CARRIER_TICK_NS;
   localparam logic [15:0] CARRIER_PERIOD = 16'(CARRIER_TICK_HZ / CARRIER_HZ);
   // Step timebase and rate limits in hertz.
   localparam int TIMEBASE_HZ = 62_500;
   localparam logic [7:0] RATE_MINIMUM = 8'h06;
   localparam logic [7:0] RATE_MAXIMUM = 8'hC8;
   // Amplitude table shape: four entries per hertz, full scale 65535.
   localparam int AMP_PER_HZ = 4;
   localparam int AMP_ENTRIES = 801;
   localparam int AMP_LOW_IDX = 24;
   localparam int AMP_MID_IDX = 400;
   localparam int AMP_TOP_IDX = 800;
   localparam int AMP_LOW = 64551;
   localparam int AMP_MID = 49151;
   localparam int AMP_TOP = 32768;
   localparam int AMP_SHIFT = 16;
   // Pair values at reset, taken at the minimum rate.
   localparam logic [15:0] INIT_DUTY = 16'((AMP_LOW * 400) >> AMP_SHIFT);
   localparam logic [15:0] INIT_STEP = 16'(TIMEBASE_HZ / 6);
   // Output config words per phase and the driven outputs behind them.
   // Drive bits: 0 is U, 1 is U inverse, 2 is V, 3 is V inverse.
   localparam logic [15:0] PHASE_WORD [8] = '{16'h2306, 16'h2302, 16'h230A, 16'h2308,
                                             16'h2309, 16'h2301, 16'h2305, 16'h2304};
   localparam logic [3:0] PHASE_DRIVE [8] = '{4'h9, 4'h1, 4'h4, 4'h4,
                                             4'h6, 4'h2, 4'hA, 4'h8};
   localparam logic [15:0] CFG_OFF = 16'h2300;
   localparam int POL_LSB = 8;
   localparam logic [3:0] WIN_OFF = 4'hF;
   // Phase states in Gray order.
   typedef enum logic [2:0] {
      PH0 = 3'h0, PH1 = 3'h1, PH2 = 3'h3, PH3 = 3'h2,
      PH4 = 3'h6, PH5 = 3'h7, PH6 = 3'h5, PH7 = 3'h4
   } usps_phase_t;
   // Drive control states in Gray order.
   typedef enum logic [1:0] {
      ST_STOP = 2'h0, ST_PRIME = 2'h1, ST_RUN = 2'h3, ST_HALT = 2'h2
   } usps_ctl_t;
endpackage

// ### design/usps_pwm_if.sv
`timescale 1ns/1ns
interface usps_pwm_if;
   logic run;
   logic cmp_wr;
   logic [15:0] cmp_val;
   logic [15:0] cfg_word;
   logic [3:0] drive;
   logic [3:0] winding_n;
   modport ctl (output run, cmp_wr, cmp_val, cfg_word, drive, input winding_n);
   modport gen (input run, cmp_wr, cmp_val, cfg_word, drive, output winding_n);
endinterface

// ### design/usps_tick_gen.sv
`timescale 1ns/1ns
module usps_tick_gen
   import usps_pkg::*;
#(
   parameter int CLK_HZ = SYS_CLK_HZ,
   parameter int TICK_HZ = CARRIER_TICK_HZ
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Tick
   output logic tick
);
   if (TICK_HZ <= 0 || TICK_HZ >= CLK_HZ) begin : g_chk
      $error("tick rate must be positive and below the clock rate");
   end

   logic [31:0] acc_q;
   logic [31:0] sum;

   // Fractional divider: the average tick rate is exact even when it does not divide the clock.
   assign sum = acc_q + 32'(TICK_HZ);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_q <= '0;
         tick <= 1'b0;
      end else if (sum >= 32'(CLK_HZ)) begin
         acc_q <= sum - 32'(CLK_HZ);
         tick <= 1'b1;
      end else begin
         acc_q <= sum;
         tick <= 1'b0;
      end
   end
endmodule

// ### design/usps_pwm_gen.sv
`timescale 1ns/1ns
module usps_pwm_gen
   import usps_pkg::*;
#(
   parameter logic [15:0] PERIOD = CARRIER_PERIOD
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Carrier tick
   input wire logic carrier_tick,
   // Control side
   usps_pwm_if.gen bus
);
   if (PERIOD < 16'h0002) begin : g_chk
      $error("carrier period must be at least two ticks");
   end

   logic [15:0] carrier_counter_q;
   logic [15:0] cmp_act_q;
   logic [15:0] cmp_buf_q;
   logic wrap;
   logic pwm_waveform;

   assign wrap = bus.run && carrier_tick && (carrier_counter_q == PERIOD - 16'h0001);
   assign pwm_waveform = bus.run && (carrier_counter_q < cmp_act_q);

   // Carrier counter; it sits at zero while stopped.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         carrier_counter_q <= '0;
      end else if (!bus.run) begin
         carrier_counter_q <= '0;
      end else if (wrap) begin
         carrier_counter_q <= '0;
      end else if (carrier_tick) begin
         carrier_counter_q <= carrier_counter_q + 16'h0001;
      end
   end

   // Compare registers: direct while stopped, buffered and applied at period end once running.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmp_act_q <= '0;
         cmp_buf_q <= '0;
      end else begin
         if (bus.cmp_wr) begin
            cmp_buf_q <= bus.cmp_val;
         end
         if (bus.cmp_wr && !bus.run) begin
            cmp_act_q <= bus.cmp_val;
         end else if (wrap) begin
            cmp_act_q <= cmp_buf_q;
         end
      end
   end

   // Each output flips straight with the carrier; no phase drives both transistors of a leg, so no dead time.
   for (genvar i = 0; i < 4; i++) begin : g_win
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            bus.winding_n[i] <= 1'b1;
         end else begin
            bus.winding_n[i] <= bus.cfg_word[POL_LSB + i / 2] ^ (bus.drive[i] && pwm_waveform);
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_direct_load;
      bus.cmp_wr && !bus.run |=> cmp_act_q == $past(bus.cmp_val);
   endproperty
   a_direct_load: assert property (p_direct_load) else $error("stopped write not direct");

   property p_buffered;
      bus.cmp_wr && bus.run && !wrap |=> cmp_act_q == $past(cmp_act_q);
   endproperty
   a_buffered: assert property (p_buffered) else $error("running write not buffered");

   property p_active_low;
      bus.run && bus.drive[0] && pwm_waveform && bus.cfg_word[POL_LSB] |=> !bus.winding_n[0];
   endproperty
   a_active_low: assert property (p_active_low) else $error("driven output not low");
endmodule

// ### design/usps_sequencer.sv
`timescale 1ns/1ns
module usps_sequencer
   import usps_pkg::*;
#(
   parameter logic [7:0] RATE_LO = RATE_MINIMUM,
   parameter logic [7:0] RATE_HI = RATE_MAXIMUM,
   parameter int CLK_HZ = SYS_CLK_HZ,
   parameter int CARRIER_CLK_HZ = CARRIER_TICK_HZ
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Commands
   input wire logic [7:0] rate_command,
   input wire logic drive_clear,
   input wire logic external_fault_in,
   // Winding drive
   output logic [3:0] winding_n,
   output logic [15:0] output_config_word,
   output logic [2:0] phase_state,
   // Status
   output logic [7:0] rate_monitor,
   output logic step_pulse,
   output logic external_fault_event
);
   // The table must cover the top rate and the slowest step must fit the 16-bit timer.
   if (RATE_LO == 8'h00 || RATE_HI < RATE_LO ||
       int'(RATE_HI) * AMP_PER_HZ >= AMP_ENTRIES ||
       TIMEBASE_HZ / int'(RATE_LO) > 65535) begin : g_chk
      $error("rate limits out of range");
   end

   usps_pwm_if pif ();

   logic carrier_tick;
   logic time_tick;
   usps_ctl_t ctl_q;
   usps_phase_t phase_q;
   logic [15:0] cfg_q;
   logic [3:0] drive_q;
   logic run_q;
   logic cmp_wr_q;
   logic [15:0] cmp_val_q;
   logic [7:0] rate_clamp_q;
   logic [7:0] rate_mon_q;
   logic [7:0] rate_clamp;
   logic [15:0] amp_table [0:AMP_ENTRIES-1];
   logic [9:0] amp_idx;
   logic [15:0] amp_word;
   logic [31:0] duty_prod;
   logic [16:0] step_quot;
   logic [15:0] duty_calc;
   logic [15:0] step_calc;
   logic [15:0] pair_duty_q;
   logic [15:0] pair_step_q;
   logic pair_new_q;
   logic pair_raise_q;
   logic [15:0] timer_q;
   logic [15:0] step_cmp_q;
   logic [15:0] last_step_q;
   logic step_due;
   logic step_cut;
   logic step_fire;
   logic step_q;
   logic fault_in_q;
   logic fault_rise;
   logic fault_evt_q;
   logic go_run;
   logic [2:0] phase_idx;
   logic [2:0] phase_nxt;

   // Carrier tick at 8 MHz on average and the step timebase tick.
   usps_tick_gen #(
      .CLK_HZ(CLK_HZ),
      .TICK_HZ(CARRIER_CLK_HZ)
   ) u_carrier_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(carrier_tick)
   );

   usps_tick_gen #(
      .CLK_HZ(CLK_HZ),
      .TICK_HZ(TIMEBASE_HZ)
   ) u_time_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(time_tick)
   );

   usps_pwm_gen #(
      .PERIOD(CARRIER_PERIOD)
   ) u_pwm (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .carrier_tick(carrier_tick),
      .bus(pif.gen)
   );

   // Control side of the waveform generator.
   assign pif.run = run_q;
   assign pif.cmp_wr = cmp_wr_q;
   assign pif.cmp_val = cmp_val_q;
   assign pif.cfg_word = cfg_q;
   assign pif.drive = drive_q;

   // Top-level outputs, all taken from flip-flops.
   assign winding_n = pif.winding_n;
   assign output_config_word = cfg_q;
   assign phase_state = phase_q;
   assign rate_monitor = rate_mon_q;
   assign step_pulse = step_q;
   assign external_fault_event = fault_evt_q;

   // Amplitude curve: flat at the low end, then two falling straight segments.
   function automatic logic [15:0] usps_amp_curve(input int idx);
      int v;
      if (idx <= AMP_LOW_IDX) begin
         v = AMP_LOW;
      end else if (idx <= AMP_MID_IDX) begin
         v = AMP_LOW - (AMP_LOW - AMP_MID) * (idx - AMP_LOW_IDX) / (AMP_MID_IDX - AMP_LOW_IDX);
      end else begin
         v = AMP_MID - (AMP_MID - AMP_TOP) * (idx - AMP_MID_IDX) / (AMP_TOP_IDX - AMP_MID_IDX);
      end
      return 16'(v);
   endfunction

   // The table is constant, so it folds into logic rather than needing a memory image.
   for (genvar g = 0; g < AMP_ENTRIES; g++) begin : g_amp
      assign amp_table[g] = usps_amp_curve(g);
   end

   // Clamp the sampled command into the allowed band.
   always_comb begin
      if (rate_command < RATE_LO) begin
         rate_clamp = RATE_LO;
      end else if (rate_command > RATE_HI) begin
         rate_clamp = RATE_HI;
      end else begin
         rate_clamp = rate_command;
      end
   end

   // Duty and step interval from the clamped rate.
   assign amp_idx = {rate_clamp_q, 2'b00};
   assign amp_word = amp_table[amp_idx];
   assign duty_prod = 32'(amp_word) * 32'(CARRIER_PERIOD);
   assign duty_calc = duty_prod[31:16];
   // Eight steps per modulation period, so the interval is the timebase over the rate.
   assign step_quot = 17'(TIMEBASE_HZ) / 17'(rate_clamp_q);
   assign step_calc = step_quot[15:0];

   // Command sampling and monitor echo.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_clamp_q <= RATE_MINIMUM;
         rate_mon_q <= RATE_MINIMUM;
      end else begin
         rate_clamp_q <= rate_clamp;
         rate_mon_q <= rate_clamp;
      end
   end

   // Duty and interval move together, so a step never mixes an old one with a new one.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pair_duty_q <= INIT_DUTY;
         pair_step_q <= INIT_STEP;
         pair_new_q <= 1'b0;
         pair_raise_q <= 1'b0;
      end else if (duty_calc != pair_duty_q || step_calc != pair_step_q) begin
         pair_duty_q <= duty_calc;
         pair_step_q <= step_calc;
         pair_new_q <= 1'b1;
         pair_raise_q <= (step_calc < pair_step_q);
      end else begin
         pair_new_q <= 1'b0;
         pair_raise_q <= 1'b0;
      end
   end

   // Fault input edge; the input is synchronous to the core clock.
   assign fault_rise = external_fault_in && !fault_in_q;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_in_q <= 1'b0;
         fault_evt_q <= 1'b0;
      end else begin
         fault_in_q <= external_fault_in;
         fault_evt_q <= fault_rise;
      end
   end

   // The drive keeps running only in prime or run with no clear and no fresh fault.
   assign go_run = !drive_clear && !fault_rise && (ctl_q == ST_PRIME || ctl_q == ST_RUN);

   // Drive control: stop, prime, run; a fault parks it in halt until a clear.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_q <= ST_STOP;
      end else if (drive_clear) begin
         ctl_q <= ST_STOP;
      end else begin
         case (ctl_q)
            ST_STOP: begin
               ctl_q <= ST_PRIME;
            end
            ST_PRIME: begin
               ctl_q <= fault_rise ? ST_HALT : ST_RUN;
            end
            ST_RUN: begin
               if (fault_rise) begin
                  ctl_q <= ST_HALT;
               end
            end
            ST_HALT: begin
               ctl_q <= ST_HALT;
            end
            default: begin
               ctl_q <= ST_STOP;
            end
         endcase
      end
   end

   // Carrier counter runs from the end of prime.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_q <= 1'b0;
      end else begin
         run_q <= go_run;
      end
   end

   // Step timer on the 62500 Hz timebase, cleared with the drive.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_q <= '0;
      end else if (drive_clear) begin
         timer_q <= '0;
      end else if (time_tick) begin
         timer_q <= timer_q + 16'h0001;
      end
   end

   // A step is due on compare match; a rate rise that has already outrun the new
   // interval cuts the current burst and steps at once.
   assign step_due = (ctl_q == ST_RUN) && time_tick && (timer_q == step_cmp_q);
   assign step_cut = (ctl_q == ST_RUN) && pair_raise_q &&
                     ((timer_q - last_step_q) >= pair_step_q);
   assign step_fire = (step_due || step_cut) && go_run;

   // Step compare scheduling in compare-only fashion.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         step_cmp_q <= '0;
         last_step_q <= '0;
      end else if (ctl_q == ST_PRIME) begin
         step_cmp_q <= timer_q + pair_step_q;
         last_step_q <= timer_q;
      end else if (step_due) begin
         step_cmp_q <= step_cmp_q + pair_step_q;
         last_step_q <= step_cmp_q;
      end else if (step_cut) begin
         step_cmp_q <= timer_q + pair_step_q;
         last_step_q <= timer_q;
      end else if (pair_raise_q) begin
         step_cmp_q <= last_step_q + pair_step_q;
      end
   end

   // Gray phase to its index, and the index one further on back to Gray.
   assign phase_idx = {phase_q[2], phase_q[2] ^ phase_q[1], ^phase_q};
   assign phase_nxt = phase_idx + 3'h1;

   // Phase sequence and output selection.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= PH1;
         cfg_q <= CFG_OFF;
         drive_q <= '0;
      end else if (!go_run) begin
         phase_q <= PH1;
         cfg_q <= CFG_OFF;
         drive_q <= '0;
      end else if (ctl_q == ST_PRIME) begin
         phase_q <= PH1;
         cfg_q <= PHASE_WORD[0];
         drive_q <= PHASE_DRIVE[0];
      end else if (step_fire) begin
         // Seven wraps to zero through the three-bit index.
         cfg_q <= PHASE_WORD[phase_idx];
         drive_q <= PHASE_DRIVE[phase_idx];
         phase_q <= usps_phase_t'(phase_nxt ^ (phase_nxt >> 1));
      end
   end

   // Compare writes: every cycle while stopped (direct), then at prime, each step and each new pair.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmp_wr_q <= 1'b0;
         cmp_val_q <= '0;
         step_q <= 1'b0;
      end else begin
         cmp_wr_q <= (ctl_q == ST_STOP) ||
                     (go_run && (ctl_q == ST_PRIME || step_fire || pair_new_q));
         cmp_val_q <= pair_duty_q;
         step_q <= step_fire;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_advance;
      step_fire && phase_q == PH3 |=> phase_q == PH4 && step_q;
   endproperty
   a_advance: assert property (p_advance) else $error("phase did not advance once");

   property p_word_zero;
      step_fire && phase_q == PH0 |=> cfg_q == 16'h2306 && phase_q == PH1 && step_q;
   endproperty
   a_word_zero: assert property (p_word_zero) else $error("phase zero word wrong");

   property p_word_two;
      step_fire && phase_q == PH2 |=> cfg_q == 16'h230A && phase_q == PH3;
   endproperty
   a_word_two: assert property (p_word_two) else $error("phase two word wrong");

   property p_word_four;
      step_fire && phase_q == PH4 |=> cfg_q == 16'h2309 && drive_q == 4'h6;
   endproperty
   a_word_four: assert property (p_word_four) else $error("phase four word wrong");

   property p_wrap;
      step_fire && phase_q == PH7 |=> phase_q == PH0 && cfg_q == 16'h2304;
   endproperty
   a_wrap: assert property (p_wrap) else $error("phase seven did not wrap");

   property p_clamp_hi;
      rate_command > RATE_HI |=> rate_clamp_q == RATE_HI && rate_monitor == RATE_HI;
   endproperty
   a_clamp_hi: assert property (p_clamp_hi) else $error("high clamp wrong");

   property p_clamp_lo;
      rate_command < RATE_LO |=> rate_clamp_q == RATE_LO && rate_monitor == RATE_LO;
   endproperty
   a_clamp_lo: assert property (p_clamp_lo) else $error("low clamp wrong");

   property p_pair;
      pair_new_q |-> pair_duty_q == $past(duty_prod[31:16]) &&
                     pair_step_q == 16'(17'd62500 / 17'($past(rate_clamp_q)));
   endproperty
   a_pair: assert property (p_pair) else $error("duty or interval pair wrong");

   property p_sched;
      step_due && go_run |=> step_cmp_q == 16'($past(step_cmp_q) + $past(pair_step_q));
   endproperty
   a_sched: assert property (p_sched) else $error("next step not one interval on");

   property p_start;
      ctl_q == ST_PRIME && go_run |=> phase_q == PH1 && cfg_q == 16'h2306 ##1 run_q;
   endproperty
   a_start: assert property (p_start) else $error("start state wrong");

   property p_clear;
      drive_clear |=> !run_q && timer_q == 16'h0000 && phase_q == PH1 ##1 winding_n == 4'hF;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not stop drive");

   property p_fault;
      fault_rise && ctl_q == ST_RUN |=> external_fault_event && !run_q && ctl_q == ST_HALT;
   endproperty
   a_fault: assert property (p_fault) else $error("fault did not shut down");
endmodule

// ### bench/usps_motor_model.sv
`timescale 1ns/1ns
module usps_motor_model (
   // Clock and counter clear
   core_clk,
   count_clear,
   // Winding pins from the drive
   winding_n,
   // Conduction tallies seen by the motor
   on_cnt,
   clash_cnt
);
   input wire logic core_clk;
   input wire logic count_clear;
   input wire logic [3:0] winding_n;
   output logic [3:0][15:0] on_cnt;
   output logic [15:0] clash_cnt;

   // A transistor conducts while its pin is low, so low cycles are counted.
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (count_clear) begin
            on_cnt[i] <= 16'h0000;
         end else if (!winding_n[i]) begin
            on_cnt[i] <= on_cnt[i] + 16'h0001;
         end
      end
   end

   // Both transistors of a leg on together would short the supply; tally it.
   always_ff @(posedge core_clk) begin
      if (count_clear) begin
         clash_cnt <= 16'h0000;
      end else if (winding_n[1:0] == 2'h0 || winding_n[3:2] == 2'h0) begin
         clash_cnt <= clash_cnt + 16'h0001;
      end
   end
endmodule

// ### bench/usps_sequencer_bench.sv
`timescale 1ns/1ns
module usps_sequencer_bench;
   import usps_pkg::*;
   localparam logic [7:0] EDGE_RATE [4] = '{8'h05, 8'h06, 8'hC8, 8'hC9};
   // The design is told its clock is 1 MHz, so a 200 Hz step takes 4992 clocks, not
   // 124800, and every phase fits in the run; carrier ticks land on every second clock.
   localparam int BENCH_CLK_HZ = 1_000_000;
   localparam int BENCH_CARRIER_HZ = 500_000;
   localparam int CPT = BENCH_CLK_HZ / BENCH_CARRIER_HZ;
   localparam int STEP_CLKS = (62_500 / 200) * (BENCH_CLK_HZ / 62_500);
   localparam int WIN = 3 * 400 * CPT;
   localparam int LOW_TOP = 3 * CPT * ((AMP_TOP * 400) >> 16);
   localparam int LOW_MID = 3 * CPT * ((AMP_MID * 400) >> 16);
   // Rule table from phase one on: config word and driven outputs at each step.
   int word_q[$] = '{16'h2302, 16'h230A, 16'h2308, 16'h2309, 16'h2301, 16'h2305, 16'h2304,
                     16'h2306};
   int mask_q[$] = '{4'h1, 4'h4, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9};
   logic core_clk, sys_rst, drive_clear, external_fault_in, count_clear;
   logic [7:0] rate_command, rate_monitor;
   logic [3:0] winding_n;
   logic [15:0] output_config_word, clash_cnt;
   logic [2:0] phase_state;
   logic step_pulse, external_fault_event;
   logic [3:0][15:0] on_cnt;
   logic [31:0] rng_state;
   int err_total, total_checks, cyc, p, w, m, last_cyc;

   usps_sequencer #(.CLK_HZ(BENCH_CLK_HZ), .CARRIER_CLK_HZ(BENCH_CARRIER_HZ)) i_usps_sequencer (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .rate_command(rate_command), .drive_clear(drive_clear),
      .external_fault_in(external_fault_in), .winding_n(winding_n),
      .output_config_word(output_config_word), .phase_state(phase_state),
      .rate_monitor(rate_monitor), .step_pulse(step_pulse),
      .external_fault_event(external_fault_event));
   usps_motor_model i_usps_motor_model (.core_clk(core_clk), .count_clear(count_clear),
      .winding_n(winding_n), .on_cnt(on_cnt), .clash_cnt(clash_cnt));

   // Free-running clock and a cycle count from reset release.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= sys_rst ? 0 : cyc + 1;

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Reference clamp of the rate command.
   function automatic logic [31:0] clamp(input logic [7:0] r);
      int v;
      v = r;
      if (v < RATE_MINIMUM) v = RATE_MINIMUM;
      if (v > RATE_MAXIMUM) v = RATE_MAXIMUM;
      return 32'(v);
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
      end
   endtask

   // Inputs always move 5 ns after the rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask

   // Tally conduction over a span; idle windings must never conduct.
   task automatic duty(input int span, input logic [3:0] act, input int want);
      count_clear = 1'b1;
      tick(1);
      count_clear = 1'b0;
      tick(span);
      for (int i = 0; i < 4; i++) begin
         check("on_cnt", act[i] ? (on_cnt[i] >= want - 60 && on_cnt[i] <= want + 60)
            : (on_cnt[i] == 16'h0000), 1'b1);
      end
   endtask

   task automatic print_verdict();
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // The run needs about 56000 cycles; a hang beyond that is cut off.
   initial begin
      #(80_000 * 40);
      err_total++;
      print_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      rate_command = 8'h00;
      drive_clear = 1'b0;
      external_fault_in = 1'b0;
      count_clear = 1'b0;
      rng_state = 32'h00016395;
      repeat (12) @(posedge core_clk);
      #5;
      check("winding_n", winding_n, 4'hF);
      check("config", output_config_word, 16'h2300);
      check("phase", phase_state, PH1);
      sys_rst = 1'b0;
      for (int i = 0; i < 24; i++) begin
         rng_state = xorshift(rng_state);
         rate_command = (i < 4) ? EDGE_RATE[i] : rng_state[7:0];
         tick(1);
         check("rate_monitor", rate_monitor, clamp(rate_command));
      end
      rate_command = RATE_MAXIMUM;
      tick(2000);
      check("config", output_config_word, 16'h2306);
      duty(WIN, 4'h9, LOW_TOP);
      p = 1;
      last_cyc = 0;
      // Nine steps at 200 Hz visit every phase; the tenth comes after a drop to 100 Hz,
      // and the eleventh is cut short by the raise back to 200 Hz.
      for (int k = 0; k < 11; k++) begin
         do tick(1); while (step_pulse !== 1'b1 && cyc < 70000);
         if (k == 0) begin
            check("step time", cyc >= STEP_CLKS && cyc <= STEP_CLKS + 48, 1'b1);
         end else if (k < 10) begin
            check("step gap", cyc - last_cyc, STEP_CLKS);
         end else begin
            check("cut step", cyc - last_cyc, 3);
         end
         last_cyc = cyc;
         w = word_q.pop_front();
         word_q.push_back(w);
         m = mask_q.pop_front();
         mask_q.push_back(m);
         p = (p + 1) % 8;
         check("config", output_config_word, w);
         check("phase", phase_state, p ^ (p >> 1));
         tick(1);
         check("step_pulse", step_pulse, 1'b0);
         if (k < 10) duty(WIN, m[3:0], (k < 9) ? LOW_TOP : LOW_MID);
         if (k == 8) rate_command = 8'h64;
         if (k == 9) begin
            // Far enough past the last step that the shorter interval has already run out.
            tick(3000);
            rate_command = RATE_MAXIMUM;
            last_cyc = cyc;
         end
      end
      check("clash", clash_cnt, 16'h0000);
      external_fault_in = 1'b1;
      tick(1);
      repeat (4) if (external_fault_event !== 1'b1) tick(1);
      check("fault event", external_fault_event, 1'b1);
      tick(1);
      check("fault event", external_fault_event, 1'b0);
      tick(2);
      check("winding_n", winding_n, 4'hF);
      check("config", output_config_word, 16'h2300);
      drive_clear = 1'b1;
      tick(2);
      check("phase", phase_state, PH1);
      drive_clear = 1'b0;
      tick(4);
      check("config", output_config_word, 16'h2306);
      print_verdict();
   end
endmodule
